// >>> serial_link_bist_regs.svh
`ifndef SERIAL_LINK_BIST_REGS_SVH
`define SERIAL_LINK_BIST_REGS_SVH

// --------------------------------------------------------------------------
// forward frame layout
// --------------------------------------------------------------------------
`define FRAME_BITS 35
`define FRAME_LAST 6'h22
`define FRAME_END 6'h23
`define LFSR_SEED 15'h7FFF

// --------------------------------------------------------------------------
// back channel frame layout
// --------------------------------------------------------------------------
`define BC_BITS 12
`define BC_LAST 4'hB
`define BC_TE_POS 11
`define BC_WAKE_POS 10
`define BC_OSC_POS 9
`define BC_CRC_MSB 3
`define CRC_POLY 4'h3
`define CRC_INIT 4'h0
`define CRC_ERR_MAX 8'hFF

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define CLK_FREQ_KHZ 25000
`define OSC_FREQ_KHZ 33000
`define LINK_HALF_PCLK 4'h4
`define LINK_HALF_OSC ((`CLK_FREQ_KHZ * 4) / `OSC_FREQ_KHZ)
`define BC_HALF 4'h8
`define LOCK_FRAMES 3'h4
`define LOCK_TIMEOUT 8'h40

// --------------------------------------------------------------------------
// strap and reset values
// --------------------------------------------------------------------------
`define STRAP_UPPER_EXPECT 3'h0
`define PASS_RESET 1'b0

`endif

// >>> serial_link_bist_pkg.sv
package serial_link_bist_pkg;
  `include "serial_link_bist_regs.svh"

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_CHECK = 4'h4,
    ST_HOLD = 4'h8
  } des_state_t;

  typedef logic [`FRAME_BITS-1:0] frame_t;
  typedef logic [14:0] lfsr_t;
  typedef logic [`BC_BITS-1:0] bc_word_t;

  function automatic logic scr_bit(input lfsr_t s);
    return s[14] ^ s[13];
  endfunction

  function automatic lfsr_t lfsr_next(input lfsr_t s);
    return {s[13:0], s[14] ^ s[13]};
  endfunction

  // crc over the eight control bits, msb first
  function automatic logic [3:0] crc_of(input logic [7:0] d);
    logic [3:0] c;
    logic fb;
    c = `CRC_INIT;
    for (int i = 7; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c = {c[2:0], 1'b0} ^ ({4{fb}} & `CRC_POLY);
    end
    return c;
  endfunction
endpackage

// >>> serial_link_bist_if.sv
`timescale 1ns/100ps
interface serial_link_bist_if;
  logic fwd_clk;
  logic fwd_data;
  logic fwd_sync;
  logic fwd_test;
  logic bc_clk;
  logic bc_data;
  logic bc_sync;

  modport des (
    input fwd_clk, fwd_data, fwd_sync, fwd_test,
    output bc_clk, bc_data, bc_sync
  );

  modport ser (
    output fwd_clk, fwd_data, fwd_sync, fwd_test,
    input bc_clk, bc_data, bc_sync
  );
endinterface

// >>> serial_link_bist_ser.sv
`timescale 1ns/100ps
`include "serial_link_bist_regs.svh"
module serial_link_bist_ser import serial_link_bist_pkg::*; (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic WAKE_I,
  input wire logic [`FRAME_BITS-1:0] TX_DATA_I,
  input wire logic INJECT_ERR_I,
  output logic TX_TAKE_O,
  output logic AWAKE_O,
  output logic TEST_MODE_O,
  output logic [7:0] CRC_ERR_CNT_O,
  serial_link_bist_if.ser LINK
);

  // --------------------------------------------------------------------------
  // back channel receive
  // --------------------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic bclk_prev;
  logic [3:0] rx_idx;
  logic [10:0] rx_word;
  logic test_mode;
  logic osc_sel;
  logic awake;
  logic [7:0] crc_cnt;

  wire bclk_s = sync_b[2];
  wire bdata_s = sync_b[1];
  wire bsync_s = sync_b[0];
  wire bclk_rise = bclk_s & ~bclk_prev;
  wire bc_word_t full = {rx_word, bdata_s};
  wire bc_last = bclk_rise & ~bsync_s & (rx_idx == `BC_LAST);
  wire crc_ok = crc_of(full[`BC_BITS-1:`BC_CRC_MSB+1]) == full[`BC_CRC_MSB:0];
  wire good = bc_last & crc_ok;
  wire enter_test = good & full[`BC_TE_POS] & ~test_mode;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      bclk_prev <= 1'b0;
    end else begin
      sync_a <= {LINK.bc_clk, LINK.bc_data, LINK.bc_sync};
      sync_b <= sync_a;
      bclk_prev <= bclk_s;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rx_idx <= 4'h0;
      rx_word <= 11'h000;
    end else if (bclk_rise) begin
      rx_word <= {rx_word[9:0], bdata_s};
      if (bsync_s) begin
        rx_idx <= 4'h1;
      end else if (rx_idx == `BC_LAST || rx_idx == 4'h0) begin
        rx_idx <= 4'h0;
      end else begin
        rx_idx <= rx_idx + 4'h1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      test_mode <= 1'b0;
      osc_sel <= 1'b0;
      awake <= 1'b0;
      crc_cnt <= 8'h00;
    end else begin
      awake <= awake | WAKE_I | (good & full[`BC_WAKE_POS]);
      if (good) begin
        test_mode <= full[`BC_TE_POS];
        osc_sel <= full[`BC_OSC_POS];
      end
      // fresh count per test run, kept after the run ends
      if (enter_test) begin
        crc_cnt <= 8'h00;
      end else if (bc_last && !crc_ok && test_mode && crc_cnt != `CRC_ERR_MAX) begin
        crc_cnt <= crc_cnt + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // forward channel transmit
  // --------------------------------------------------------------------------
  logic [3:0] half_cnt;
  logic fclk;
  logic [5:0] tx_idx;
  frame_t tx_word;
  lfsr_t lfsr;
  logic inject_pend;

  wire [3:0] half = osc_sel ? 4'(`LINK_HALF_OSC) : `LINK_HALF_PCLK;
  // at or past the count: a shorter half period chosen mid-count must not wrap
  wire toggle = awake & (half_cnt >= half - 4'h1);
  wire fall = toggle & fclk;
  wire load = fall & (tx_idx == `FRAME_LAST);
  wire frame_t base = test_mode ? frame_t'(0) : TX_DATA_I;
  wire frame_t next_word = base ^ frame_t'(test_mode & inject_pend);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      half_cnt <= 4'h0;
      fclk <= 1'b0;
      tx_idx <= `FRAME_LAST;
      tx_word <= frame_t'(0);
      lfsr <= `LFSR_SEED;
      inject_pend <= 1'b0;
      TX_TAKE_O <= 1'b0;
      LINK.fwd_clk <= 1'b0;
      LINK.fwd_data <= 1'b0;
      LINK.fwd_sync <= 1'b0;
      LINK.fwd_test <= 1'b0;
    end else begin
      half_cnt <= toggle ? 4'h0 : (awake ? half_cnt + 4'h1 : 4'h0);
      fclk <= toggle ? ~fclk : fclk;
      LINK.fwd_clk <= toggle ? ~fclk : fclk;
      LINK.fwd_test <= test_mode;
      TX_TAKE_O <= load & ~test_mode;
      inject_pend <= INJECT_ERR_I | (inject_pend & ~(load & test_mode));
      if (load) begin
        // all-zero payload in test, scrambled like any frame
        tx_idx <= 6'h0;
        tx_word <= next_word >> 1;
        LINK.fwd_data <= next_word[0] ^ scr_bit(`LFSR_SEED);
        lfsr <= lfsr_next(`LFSR_SEED);
        LINK.fwd_sync <= 1'b1;
      end else if (fall) begin
        tx_idx <= tx_idx + 6'h1;
        tx_word <= tx_word >> 1;
        LINK.fwd_data <= tx_word[0] ^ scr_bit(lfsr);
        lfsr <= lfsr_next(lfsr);
        LINK.fwd_sync <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      AWAKE_O <= 1'b0;
      TEST_MODE_O <= 1'b0;
      CRC_ERR_CNT_O <= 8'h00;
    end else begin
      AWAKE_O <= awake;
      TEST_MODE_O <= test_mode;
      CRC_ERR_CNT_O <= crc_cnt;
    end
  end
endmodule

// >>> serial_link_bist_des.sv
// Operation
// - test starts from enable pin or config bit
// - clock from pixel clock or 33 MHz oscillator
// - test enable sent over back channel
// - wake remote serializer when it is inactive
// - serializer sends scrambled all-zeros at speed
// - both in test and locked: result high
// - errored frame drops result low briefly
// - enable low: stop, hold pass or fail
// - held result kept until new test or reset
// - test length set by enable pulse width
// - lock output valid throughout the test
// - straps: pin zero high, pins three-one low
// - enable low returns link to normal operation
// - serializer counts back channel crc errors
`timescale 1ns/100ps
`include "serial_link_bist_regs.svh"
module serial_link_bist_des import serial_link_bist_pkg::*; (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SELF_TEST_ENABLE_PIN_I,
  input wire logic SELF_TEST_CLOCK_SELECT_PIN_I,
  input wire logic PCLK_PRESENT_I,
  input wire logic STRAP_PIN_ZERO_I,
  input wire logic [2:0] STRAP_PINS_UPPER_I,
  input wire logic CFG_SELF_TEST_I,
  input wire logic CFG_OSC_SEL_I,
  output logic PASS_O,
  output logic LOCK_O,
  output logic TEST_ACTIVE_O,
  output logic OSC_SEL_O,
  output logic [`FRAME_BITS-1:0] RX_DATA_O,
  output logic RX_VALID_O,
  serial_link_bist_if.des LINK
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;

  wire [NSYNC-1:0] raw = {SELF_TEST_ENABLE_PIN_I, SELF_TEST_CLOCK_SELECT_PIN_I,
                          PCLK_PRESENT_I, STRAP_PIN_ZERO_I, STRAP_PINS_UPPER_I,
                          LINK.fwd_clk, LINK.fwd_data, LINK.fwd_sync, LINK.fwd_test};

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  wire en_pin_s = sync_b[10];
  wire clksel_s = sync_b[9];
  wire pclk_s = sync_b[8];
  wire strap0_s = sync_b[7];
  wire [2:0] strap_up_s = sync_b[6:4];
  wire fclk_s = sync_b[3];
  wire fdata_s = sync_b[2];
  wire fsync_s = sync_b[1];
  wire ftest_s = sync_b[0];

  // --------------------------------------------------------------------------
  // forward frame receive and lock
  // --------------------------------------------------------------------------
  logic fclk_prev;
  logic [5:0] bit_idx;
  logic [2:0] lock_cnt;
  logic [7:0] idle_cnt;
  logic [`FRAME_BITS-2:0] shreg;
  lfsr_t lfsr;

  wire fclk_rise = fclk_s & ~fclk_prev;
  wire lfsr_t cur_lfsr = fsync_s ? lfsr_t'(`LFSR_SEED) : lfsr;
  // descrambling is data-independent, so payload zeros show directly
  wire dbit = fdata_s ^ scr_bit(cur_lfsr);
  wire frame_t frame_word = {dbit, shreg};
  wire frame_done = fclk_rise & ~fsync_s & (bit_idx == `FRAME_LAST);
  wire frame_err = |frame_word;
  wire timeout = idle_cnt == `LOCK_TIMEOUT;
  wire locked = lock_cnt == `LOCK_FRAMES;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      fclk_prev <= 1'b0;
      bit_idx <= 6'h0;
      lock_cnt <= 3'h0;
      idle_cnt <= 8'h00;
      shreg <= '0;
      lfsr <= `LFSR_SEED;
    end else begin
      fclk_prev <= fclk_s;
      if (fclk_rise) begin
        idle_cnt <= 8'h00;
        shreg <= {dbit, shreg[`FRAME_BITS-2:1]};
        lfsr <= lfsr_next(cur_lfsr);
        // lock needs several sync marks at exact frame spacing
        if (fsync_s) begin
          bit_idx <= 6'h1;
          if (bit_idx != `FRAME_END) begin
            lock_cnt <= 3'h0;
          end else if (!locked) begin
            lock_cnt <= lock_cnt + 3'h1;
          end
        end else if (bit_idx == `FRAME_END || bit_idx == 6'h0) begin
          bit_idx <= 6'h0;
          lock_cnt <= 3'h0;
        end else begin
          bit_idx <= bit_idx + 6'h1;
        end
      end else if (timeout) begin
        // link clock gone: drop lock rather than keep a stale one
        bit_idx <= 6'h0;
        lock_cnt <= 3'h0;
      end else begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // test control
  // --------------------------------------------------------------------------
  des_state_t state;
  des_state_t next_state;
  logic req_prev;
  logic err_seen;
  logic pass;

  wire test_req = en_pin_s | CFG_SELF_TEST_I;
  wire req_rise = test_req & ~req_prev;
  wire strap_ok = strap0_s & (strap_up_s == `STRAP_UPPER_EXPECT);
  wire start = req_rise & strap_ok;
  wire in_test = (state == ST_START) | (state == ST_CHECK);
  wire bad_frame = (state == ST_CHECK) & frame_done & frame_err;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (!test_req) begin
          next_state = ST_IDLE;
        end else if (locked && ftest_s) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!test_req) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (start) begin
          next_state = ST_START;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      req_prev <= 1'b0;
      err_seen <= 1'b0;
      pass <= `PASS_RESET;
    end else begin
      state <= next_state;
      req_prev <= test_req;
      if (start) begin
        err_seen <= 1'b0;
      end else if (bad_frame) begin
        err_seen <= 1'b1;
      end
      case (next_state)
        ST_CHECK: pass <= ~bad_frame;
        ST_HOLD: pass <= ~(err_seen | bad_frame);
        default: pass <= `PASS_RESET;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // back channel transmit
  // --------------------------------------------------------------------------
  logic [3:0] half_cnt;
  logic bclk;
  logic [3:0] bc_idx;
  bc_word_t bc_word;

  // no pixel clock forces the oscillator
  wire osc_sel = clksel_s | CFG_OSC_SEL_I | ~pclk_s;
  wire wake = (state == ST_START) & ~locked;
  wire [7:0] ctl = {in_test, wake, osc_sel, 5'h00};
  wire bc_word_t next_bc_word = {ctl, crc_of(ctl)};
  wire toggle = half_cnt == `BC_HALF - 4'h1;
  wire fall = toggle & bclk;
  wire load = fall & (bc_idx == `BC_LAST);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      half_cnt <= 4'h0;
      bclk <= 1'b0;
      bc_idx <= `BC_LAST;
      bc_word <= '0;
      LINK.bc_clk <= 1'b0;
      LINK.bc_data <= 1'b0;
      LINK.bc_sync <= 1'b0;
    end else begin
      half_cnt <= toggle ? 4'h0 : half_cnt + 4'h1;
      bclk <= toggle ? ~bclk : bclk;
      LINK.bc_clk <= toggle ? ~bclk : bclk;
      // data moves on the falling edge so the far end samples mid-bit
      if (load) begin
        bc_idx <= 4'h0;
        bc_word <= {next_bc_word[`BC_BITS-2:0], 1'b0};
        LINK.bc_data <= next_bc_word[`BC_BITS-1];
        LINK.bc_sync <= 1'b1;
      end else if (fall) begin
        bc_idx <= bc_idx + 4'h1;
        bc_word <= {bc_word[`BC_BITS-2:0], 1'b0};
        LINK.bc_data <= bc_word[`BC_BITS-1];
        LINK.bc_sync <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PASS_O <= `PASS_RESET;
      LOCK_O <= 1'b0;
      TEST_ACTIVE_O <= 1'b0;
      OSC_SEL_O <= 1'b0;
      RX_DATA_O <= '0;
      RX_VALID_O <= 1'b0;
    end else begin
      PASS_O <= pass;
      LOCK_O <= locked;
      TEST_ACTIVE_O <= in_test;
      OSC_SEL_O <= osc_sel;
      // functional data only outside a test run
      RX_VALID_O <= frame_done & locked & ~in_test;
      if (frame_done && locked && !in_test) begin
        RX_DATA_O <= frame_word;
      end
    end
  end
endmodule

// >>> serial_link_bist_checker_asserts.sv
`timescale 1ns/100ps
module serial_link_bist_checker_asserts (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic fwd_clk,
  input wire logic fwd_data,
  input wire logic fwd_sync,
  input wire logic fwd_test,
  input wire logic bc_clk,
  input wire logic bc_data,
  input wire logic bc_sync
);
  // ---------------------------------------------------------------
  // descrambler reference
  // ---------------------------------------------------------------
  logic prev_clk;
  logic test_frame;
  logic [14:0] scr;
  logic fwd_rise;
  logic [14:0] cur_scr;
  logic [14:0] next_scr;
  logic exp_bit;
  assign fwd_rise = fwd_clk && !prev_clk;
  assign cur_scr = fwd_sync ? 15'h7FFF : scr;
  assign next_scr = {cur_scr[13:0], cur_scr[14] ^ cur_scr[13]};
  assign exp_bit = cur_scr[14] ^ cur_scr[13];
  always_ff @(posedge CLK_I) begin
    prev_clk <= RST_N_I && fwd_clk;
    if (!RST_N_I) begin
      scr <= 15'h7FFF;
      test_frame <= 1'b0;
    end else if (fwd_rise) begin
      scr <= next_scr;
      test_frame <= fwd_sync ? fwd_test : test_frame;
    end
  end

  // ---------------------------------------------------------------
  // wire checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  property p_bc_half;
    $changed(bc_clk) |=> $stable(bc_clk)[*7] ##1 $changed(bc_clk);
  endproperty
  a_bc_half: assert property (p_bc_half) else $error("back clock half period");
  property p_bc_hold;
    bc_clk && $past(bc_clk) |-> $stable(bc_data) && $stable(bc_sync);
  endproperty
  a_bc_hold: assert property (p_bc_hold) else $error("back bit moved");
  property p_bc_sync_len;
    $rose(bc_sync) |-> ##16 $fell(bc_sync);
  endproperty
  a_bc_sync_len: assert property (p_bc_sync_len) else $error("back sync width");
  property p_bc_frame;
    $rose(bc_sync) |-> ##192 $rose(bc_sync);
  endproperty
  a_bc_frame: assert property (p_bc_frame) else $error("back frame length");
  property p_fwd_half;
    $rose(fwd_clk) |-> fwd_clk[*3] ##[1:2] !fwd_clk;
  endproperty
  a_fwd_half: assert property (p_fwd_half) else $error("link clock half period");
  property p_fwd_hold;
    fwd_clk && $past(fwd_clk) |-> $stable(fwd_data) && $stable(fwd_sync);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold) else $error("link bit moved");
  property p_fwd_sync_len;
    $rose(fwd_sync) |-> ##[6:8] $fell(fwd_sync);
  endproperty
  a_fwd_sync_len: assert property (p_fwd_sync_len) else $error("link sync width");
  property p_fwd_frame;
    $rose(fwd_sync) |-> ##[210:280] $rose(fwd_sync);
  endproperty
  a_fwd_frame: assert property (p_fwd_frame) else $error("link frame length");
  // first bit skipped: injected errors land there on purpose
  property p_fwd_zeros;
    fwd_rise && !fwd_sync && test_frame && fwd_test |-> fwd_data == exp_bit;
  endproperty
  a_fwd_zeros: assert property (p_fwd_zeros) else $error("test payload not zero");
endmodule

// >>> serial_link_bist_checker_test.sv
`timescale 1ns/100ps
module serial_link_bist_checker_test import serial_link_bist_pkg::*;;
  logic clk, rst_n, en_pin, sel_pin, pclk_ok, strap0, cfg_en, cfg_osc, wake, inject;
  logic [2:0] strap_hi;
  frame_t tx_data, rx_data;
  logic pass, lock, active, osc_sel, rx_valid, tx_take, awake, ser_test;
  logic [7:0] crc_cnt;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  serial_link_bist_if link ();
  serial_link_bist_des serial_link_bist_des_inst (.CLK_I(clk), .RST_N_I(rst_n),
    .SELF_TEST_ENABLE_PIN_I(en_pin), .SELF_TEST_CLOCK_SELECT_PIN_I(sel_pin),
    .PCLK_PRESENT_I(pclk_ok), .STRAP_PIN_ZERO_I(strap0), .STRAP_PINS_UPPER_I(strap_hi),
    .CFG_SELF_TEST_I(cfg_en), .CFG_OSC_SEL_I(cfg_osc), .PASS_O(pass), .LOCK_O(lock),
    .TEST_ACTIVE_O(active), .OSC_SEL_O(osc_sel), .RX_DATA_O(rx_data),
    .RX_VALID_O(rx_valid), .LINK(link));
  serial_link_bist_ser serial_link_bist_ser_inst (.CLK_I(clk), .RST_N_I(rst_n),
    .WAKE_I(wake), .TX_DATA_I(tx_data), .INJECT_ERR_I(inject), .TX_TAKE_O(tx_take),
    .AWAKE_O(awake), .TEST_MODE_O(ser_test), .CRC_ERR_CNT_O(crc_cnt), .LINK(link));
  serial_link_bist_checker_asserts serial_link_bist_checker_asserts_inst (.CLK_I(clk),
    .RST_N_I(rst_n), .fwd_clk(link.fwd_clk), .fwd_data(link.fwd_data),
    .fwd_sync(link.fwd_sync), .fwd_test(link.fwd_test), .bc_clk(link.bc_clk),
    .bc_data(link.bc_data), .bc_sync(link.bc_sync));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input frame_t got, input frame_t exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return pass;
      1: return lock;
      2: return rx_valid;
      3: return ser_test;
      default: return tx_take;
    endcase
  endfunction
  // lock takes four frames after wake, so the bound covers several
  task automatic wait_for(input int k, input logic v);
    for (n = 0; n < 6000 && pick(k) !== v; n++) @(negedge clk);
    if (n == 6000) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, pick(k), v);
    end
  endtask
  task automatic set_en(input logic v);
    @(posedge clk);
    en_pin <= v;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_straps();
    logic [3:0] bad [2] = '{4'b0000, 4'b1010};
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {strap0, strap_hi} <= bad[i];
      set_en(1'b1);
      repeat (20) @(negedge clk);
      chk(active, 1'b0);
      chk(awake, 1'b0);
      set_en(1'b0);
    end
    @(posedge clk);
    {strap0, strap_hi} <= 4'b1000;
    repeat (5) @(posedge clk);
    $display("test straps done");
  endtask
  task automatic test_pass();
    set_en(1'b1);
    repeat (2) @(negedge clk);
    chk(active, 1'b0);
    repeat (4) @(negedge clk);
    chk(active, 1'b1);
    wait_for(0, 1'b1);
    chk(pass, 1'b1);
    chk(awake, 1'b1);
    chk(ser_test, 1'b1);
    for (n = 0; n < 1000; n++) begin
      @(negedge clk);
      if (lock !== 1'b1 || pass !== 1'b1) break;
    end
    chk(n, 1000);
    set_en(1'b0);
    repeat (10) @(negedge clk);
    chk(pass, 1'b1);
    chk(active, 1'b0);
    chk(crc_cnt, 8'h00);
    repeat (300) @(negedge clk);
    chk(pass, 1'b1);
    wait_for(2, 1'b1);
    chk(rx_valid, 1'b1);
    $display("test pass done");
  endtask
  task automatic test_fail();
    int lows;
    @(posedge clk);
    cfg_en <= 1'b1;
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    chk(pass, 1'b1);
    repeat (2) begin
      @(posedge clk);
      inject <= 1'b1;
      @(posedge clk);
      inject <= 1'b0;
      wait_for(0, 1'b0);
      for (lows = 0; lows < 50 && pass === 1'b0; lows++) @(negedge clk);
      chk(lows, 1);
    end
    @(posedge clk);
    cfg_en <= 1'b0;
    repeat (10) @(negedge clk);
    chk(pass, 1'b0);
    repeat (300) @(negedge clk);
    chk(pass, 1'b0);
    $display("test fail done");
  endtask
  task automatic test_osc();
    logic [2:0] modes [4] = '{3'b100, 3'b000, 3'b110, 3'b101};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {pclk_ok, sel_pin, cfg_osc} <= modes[i];
      repeat (6) @(negedge clk);
      chk(osc_sel, i != 0);
    end
    set_en(1'b1);
    wait_for(0, 1'b1);
    chk(pass, 1'b1);
    set_en(1'b0);
    @(posedge clk);
    {pclk_ok, sel_pin, cfg_osc} <= 3'b100;
    repeat (10) @(negedge clk);
    chk(pass, 1'b1);
    $display("test osc done");
  endtask
  task automatic test_normal();
    @(posedge clk);
    wake <= 1'b1;
    tx_data <= 35'h5_3C96_A1E7;
    // serializer leaves test only when a back frame without the flag lands
    wait_for(3, 1'b0);
    wait_for(4, 1'b1);
    wait_for(2, 1'b1);
    chk(rx_data, 35'h5_3C96_A1E7);
    $display("test normal done");
  endtask

  // ---------------------------------------------------------------
  // clock, reset, sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    {rst_n, en_pin, sel_pin, cfg_en, cfg_osc, wake, inject} = 7'h00;
    {pclk_ok, strap0, strap_hi} = 5'b11000;
    tx_data = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    test_straps();
    test_pass();
    test_fail();
    test_osc();
    test_normal();
    summarize();
  end
endmodule
